// ---- useq_defs.svh ----
/*
 Field codes and bit positions of the next-address block.
 Assumes inclusion by bare name.
*/
`ifndef USEQ_DEFS_SVH
`define USEQ_DEFS_SVH
// Sample and memory-op field codes
`define SF_NONE 2'h0
`define SF_UNCOND 2'h1
`define SF_PAGE 2'h2
`define IM_IO_HI 3'h7
`define IM_BYTE_LO 2'h3
// Test and register extract codes
`define TF_NONE 2'h0
`define TF_PASS_FALSE 2'h3
`define AB_EXTRACT_A 2'h1
`define AB_EXTRACT_B 2'h2
// Condition select bits and codes
`define GF_PAGE_BIT 2
`define GF_SAMPLE_BIT 1
`define GF_OVF_BIT 3
`define GF_OVF_SET 2'h1
`define GF_OVF_CLR 2'h2
`define GF_OVF_LOAD 2'h3
`define GF_IR_DIRECTED_TEST 4'h5
`define GF_SHIFT_COUNTER_OVERFLOW 4'hc
// Field select codes
`define FS_ONES 4'h0
`define FS_INT 4'h1
`define FS_SHIFT 4'h2
`define FS_STEP 4'h3
`define FS_IR_BASE 4'h4
// Data bit positions and the shift counter's minus-one value
`define SIGN_BIT 15
`define NORMALIZE_FLAG_BIT 14
`define IR_DIRECTED_TEST_OVF_BIT 0
`define SHIFT_CNT_MINUS1 8'hff
// Register bus
`define AXI_AW 4
`define CTRL_OFF 4'h0
`define STATUS_OFF 4'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- useq_pkg.sv ----
/*
 Types of the next-address block.
 Assumes useq_defs.svh is on the include path.
*/
`include "useq_defs.svh"
package useq_pkg;
   // Current microword fields that steer sequencing
   typedef struct packed {
      logic [3:0] field_select_code;
      logic [3:0] low_mask_field;
      logic high_mask_bit;
      logic [3:0] address_modifier_field;
      logic [4:0] high_address_field;
      logic [1:0] register_extract_field;
      logic [1:0] sample_field;
      logic [3:0] memory_op_field;
      logic [1:0] test_field;
      logic [3:0] condition_select;
      logic direction_bit;
      logic shift_enable_value;
      logic shift_control_field;
      logic [1:0] literal_field;
   } microword_t;
   // Datapath observations for this microinstruction
   typedef struct packed {
      logic [15:0] alu_out;
      logic a_in_sign, b_in_sign, a_reg_sign, a_reg_lsb, a_shifted;
      logic alu_carry, alu_overflow, input_register_sign, register_zero_sign;
      logic [7:0] shift_count;
      logic io_sense_response;
      logic [2:0] gpr_test;
      logic interrupt_flag;
   } datapath_t;
   typedef struct packed {
      logic overflow_flag, shift_flag, normalize_flag, quotient_flag;
      logic multiply_sign_flag, byte_address_flag, alu_all_ones;
      logic alu_sign_flag, alu_carry_flag, alu_zero_flag;
   } flags_t;
   typedef struct packed {
      logic console_step, sense_switch_three;
      logic sense_switch_two, sense_switch_one;
   } switches_t;
   typedef struct packed {
      flags_t flags;
      logic [8:0] cs_addr;
      logic passed, byte_right;
      switches_t sw;
      logic awready, wready, aw_hold;
      logic [`AXI_AW-1:0] aw_addr;
      logic w_hold;
      logic [3:0] w_bits;
      logic w_lane0, bvalid;
      logic [1:0] bresp;
      logic arready, rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;
endpackage : useq_pkg

// ---- useq_cond.sv ----
/*
 Condition mux over sixteen test sources.
 Assumes registered flags, so tests see last cycle's values.
*/
`timescale 1ns/1ps
`include "useq_defs.svh"
module useq_cond
(
   input wire logic [3:0] condition_select, // Condition code
   input wire logic [15:0] ir, // Instruction register
   input wire useq_pkg::flags_t flags, // Registered flags
   input wire useq_pkg::datapath_t dp, // Datapath observations
   input wire useq_pkg::switches_t sw, // Panel switches
   output logic cond // Selected condition
);
   logic positive;
   logic ir_directed_test;
   logic shift_counter_overflow;
   logic [8:0] ir_directed_test_src;
   logic [15:0] cond_vec;

   // Counter at minus one counts as overflow
   assign shift_counter_overflow =
      (dp.shift_count == `SHIFT_CNT_MINUS1);
   assign positive = ~flags.alu_sign_flag & ~flags.alu_zero_flag;

   // Nine IR bits enable tests that are all looked at at once
   assign ir_directed_test_src = {sw.sense_switch_three, sw.sense_switch_two,
      sw.sense_switch_one, dp.gpr_test, flags.alu_sign_flag, positive,
      flags.overflow_flag};
   assign ir_directed_test = |(ir[8:0] & ir_directed_test_src);

   // Position in the vector is the condition code
   assign cond_vec = {flags.quotient_flag, flags.normalize_flag,
      dp.register_zero_sign, shift_counter_overflow,
      dp.input_register_sign, flags.shift_flag, flags.alu_zero_flag,
      flags.alu_carry_flag, flags.alu_sign_flag, flags.alu_all_ones,
      ir_directed_test, sw.sense_switch_one, sw.sense_switch_two,
      sw.sense_switch_three, dp.io_sense_response,
      flags.overflow_flag};
   assign cond = cond_vec[condition_select];
endmodule : useq_cond

// ---- useq_next_addr.sv ----
/*
 Next-address, test and flag logic with an AXI4-Lite
 slave for panel switches and status.
 Assumes microword, IR and datapath inputs are stable and synchronous to
 aclk for one microinstruction cycle per clock.
*/
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
// How it works
// - Field selection used for any nonzero select code
// - IR field of up to five bits
// - Each contribution bit ANDed with its mask
// - I/O request forces contribution bit four low
// - Address bits four to eight from high field
// - Modifier field ORed into address bits one-four
// - Modifier OR suppressed in listed exclusion cases
// - Code 0 all ones; code 1 inverted interrupt
// - Code 2 shift/byte flags; code 3 step
// - Codes 4-F take shifted IR bits
// - Sequential addressing is code zero, mask off
// - Test passes on true or false, else fail
// - Sixteen condition sources in fixed order
// - IR-directed test over nine IR bits
// - Overflow clears on reset, clear code or passing IR-directed test with IR bit 0 set
// - Shift flag copies A register sign
// - Normalize flag tracks ALU bits 15/14 mismatch
// - Quotient flag copies ALU sign conditionally
// - Multiply sign on two of three signs
// - Byte flag copies shifted register bit 0
// - Byte flag selects left or right byte
// - Tests see flag values from previous cycle
// - ALU flags update only when sampling coded
// - Shift counter overflow at minus one
// - Overflow sampling sets but never clears
`timescale 1ns/1ps
`include "useq_defs.svh"
module useq_next_addr
(
   input wire logic aclk, // Processor clock
   input wire logic aresetn, // System reset, active low
   input wire useq_pkg::microword_t mw, // Current microword
   input wire logic [15:0] ir, // Instruction register
   input wire useq_pkg::datapath_t dp, // Datapath observations
   output logic [8:0] cs_addr, // Control store address
   output logic cond_passed, // Last test passed
   output logic byte_select_right, // Byte store lane
   output useq_pkg::flags_t flags, // Processor flags
   input wire logic [`AXI_AW-1:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [`AXI_AW-1:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready // Read data ready
);
   useq_pkg::state_t st_reg;
   useq_pkg::state_t st_next;
   logic io_req;
   logic ints_allowed;
   logic page_jump;
   logic testing;
   logic ts_block;
   logic sampling;
   logic byte_store;
   logic byte_address_flag_now;
   logic cond;
   logic pass;
   logic [4:0] contrib;
   logic [4:0] mask;
   logic [15:0] ir_shift;
   logic [8:0] field_addr;
   logic [8:0] fail_addr;
   logic [8:0] ts_part;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;

   // Microword decodes
   assign io_req = (mw.sample_field == `SF_NONE) &&
      (mw.memory_op_field[3:1] == `IM_IO_HI);
   assign testing = (mw.test_field != `TF_NONE);
   assign ints_allowed = (mw.sample_field == `SF_NONE) && !testing &&
      mw.condition_select[`GF_PAGE_BIT];
   assign page_jump = !testing && (mw.sample_field == `SF_PAGE) &&
      mw.condition_select[`GF_PAGE_BIT];
   assign ts_block = (mw.register_extract_field == `AB_EXTRACT_A) ||
      (mw.register_extract_field == `AB_EXTRACT_B) || ints_allowed ||
      io_req || page_jump || testing;
   assign sampling = !mw.sample_field[0] && !testing &&
      mw.condition_select[`GF_SAMPLE_BIT];
   assign byte_store = (mw.sample_field != `SF_NONE) &&
      (mw.memory_op_field[1:0] == `IM_BYTE_LO);

   // Byte flag follows the shifted register within this cycle
   assign byte_address_flag_now = dp.a_shifted ? dp.a_reg_lsb :
      st_reg.flags.byte_address_flag;

   // IR window slides one bit per code above four
   assign ir_shift = ir >> (mw.field_select_code - `FS_IR_BASE);

   // Contribution per select code; flags are last cycle's values
   always_comb
   begin
      unique case (mw.field_select_code)
         `FS_ONES: contrib = '1;
         `FS_INT: contrib = {4'hf, ~dp.interrupt_flag};
         `FS_SHIFT: contrib = {3'h7, st_reg.flags.shift_flag,
            st_reg.flags.byte_address_flag};
         `FS_STEP: contrib = {4'hf, st_reg.sw.console_step};
         default: contrib = ir_shift[4:0];
      endcase
   end

   // An I/O request reuses mask bit four
   assign mask = {mw.high_mask_bit & ~io_req, mw.low_mask_field};

   // Modifier lands on bits one to four
   assign ts_part = {4'h0, mw.address_modifier_field, 1'b0};

   // Code zero with the whole mask off is plain sequencing
   assign field_addr = {mw.high_address_field, 4'h0} |
      {4'h0, contrib & mask} | (ts_block ? 9'h000 : ts_part);

   // Fail address stays even and in the same 32-word block as the pass address
   assign fail_addr = {mw.high_address_field, 4'h0} | ts_part;

   useq_cond u_cond
   (
      .condition_select(mw.condition_select),
      .ir(ir),
      .flags(st_reg.flags),
      .dp(dp),
      .sw(st_reg.sw),
      .cond(cond)
   );

   // Code 11 inverts the sense; other nonzero codes pass on true
   assign pass = (mw.test_field == `TF_PASS_FALSE) ? ~cond : cond;

   assign aw_fire = awvalid & st_reg.awready;
   assign w_fire = wvalid & st_reg.wready;
   assign ar_fire = arvalid & st_reg.arready;

   // Next state
   always_comb
   begin
      st_next = st_reg;
      // New address every microinstruction
      st_next.cs_addr = (testing && !pass) ? fail_addr : field_addr;
      st_next.passed = testing && pass;
      if (byte_store)
      begin
         st_next.byte_right = byte_address_flag_now;
      end
      st_next.flags.byte_address_flag = byte_address_flag_now;
      st_next.flags.normalize_flag = dp.alu_out[`SIGN_BIT] ^
         dp.alu_out[`NORMALIZE_FLAG_BIT];
      st_next.flags.multiply_sign_flag =
         (dp.alu_out[`SIGN_BIT] & dp.a_in_sign) |
         (dp.alu_out[`SIGN_BIT] & dp.b_in_sign) |
         (dp.a_in_sign & dp.b_in_sign);
      if (!mw.literal_field[1] && mw.shift_enable_value)
      begin
         st_next.flags.shift_flag = dp.a_reg_sign;
      end
      if (!mw.literal_field[1] && mw.direction_bit &&
         !mw.shift_control_field)
      begin
         st_next.flags.quotient_flag = dp.alu_out[`SIGN_BIT];
      end
      // All four ALU flags move together or not at all
      if (sampling)
      begin
         st_next.flags.alu_all_ones = &dp.alu_out;
         st_next.flags.alu_sign_flag = dp.alu_out[`SIGN_BIT];
         st_next.flags.alu_carry_flag = dp.alu_carry;
         st_next.flags.alu_zero_flag = ~|dp.alu_out;
      end
      // Unconditional overflow control
      if (mw.sample_field == `SF_UNCOND)
      begin
         if (mw.condition_select[2:1] == `GF_OVF_SET)
         begin
            st_next.flags.overflow_flag = 1'b1;
         end
         else if (mw.condition_select[2:1] == `GF_OVF_CLR)
         begin
            st_next.flags.overflow_flag = 1'b0;
         end
         else if (mw.condition_select[2:1] == `GF_OVF_LOAD &&
            dp.alu_overflow)
         begin
            st_next.flags.overflow_flag = 1'b1;
         end
      end
      // Data-loop sampling may only set the flag
      if (mw.sample_field == `SF_NONE &&
         mw.condition_select[`GF_OVF_BIT] && dp.alu_overflow)
      begin
         st_next.flags.overflow_flag = 1'b1;
      end
      if (testing && pass && mw.condition_select == `GF_IR_DIRECTED_TEST &&
         ir[`IR_DIRECTED_TEST_OVF_BIT])
      begin
         st_next.flags.overflow_flag = 1'b0;
      end
      // Address and data may come in either order
      if (aw_fire)
      begin
         st_next.aw_hold = 1'b1;
         st_next.aw_addr = awaddr;
      end
      if (w_fire)
      begin
         st_next.w_hold = 1'b1;
         st_next.w_bits = wdata[3:0];
         st_next.w_lane0 = wstrb[0];
      end
      if (st_reg.bvalid && bready)
      begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid)
      begin
         st_next.aw_hold = 1'b0;
         st_next.w_hold = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = `RESP_OKAY;
         if (st_reg.aw_addr == `CTRL_OFF)
         begin
            if (st_reg.w_lane0)
            begin
               st_next.sw = useq_pkg::switches_t'(st_reg.w_bits);
            end
         end
         else if (st_reg.aw_addr != `STATUS_OFF)
         begin
            st_next.bresp = `RESP_SLVERR;
         end
      end
      // Ready drops while a beat is held, so nothing is overwritten
      st_next.awready = !st_next.aw_hold && !st_next.bvalid;
      st_next.wready = !st_next.w_hold && !st_next.bvalid;
      // Read answers one cycle after the address
      if (st_reg.rvalid && rready)
      begin
         st_next.rvalid = 1'b0;
      end
      if (ar_fire)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp = `RESP_OKAY;
         st_next.rdata = 32'h0000_0000;
         if (araddr == `CTRL_OFF)
         begin
            st_next.rdata = {28'h0000000, st_reg.sw};
         end
         else if (araddr == `STATUS_OFF)
         begin
            st_next.rdata = {7'h00, st_reg.cs_addr, 6'h00, st_reg.flags};
         end
         else
         begin
            st_next.rresp = `RESP_SLVERR;
         end
      end
      st_next.arready = !st_next.rvalid;
   end

   // Single state register; reset clears every flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign cs_addr = st_reg.cs_addr;
   assign cond_passed = st_reg.passed;
   assign byte_select_right = st_reg.byte_right;
   assign flags = st_reg.flags;
   assign awready = st_reg.awready;
   assign wready = st_reg.wready;
   assign bvalid = st_reg.bvalid;
   assign bresp = st_reg.bresp;
   assign arready = st_reg.arready;
   assign rvalid = st_reg.rvalid;
   assign rdata = st_reg.rdata;
   assign rresp = st_reg.rresp;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Address and flag checks
   a_addr_high_field: assert property (
      ##1 cs_addr[8:5] == $past(mw.high_address_field[4:1]))
      else $error("high bits wrong");
   a_mask_zero_low: assert property (
      (!testing && mw.low_mask_field == 4'h0 && ts_block)
      |=> cs_addr[3:0] == 4'h0)
      else $error("mask ignored");
   a_io_bit_four: assert property (
      (io_req && !testing && !mw.high_address_field[0])
      |=> !cs_addr[4])
      else $error("io bit four set");
   a_modifier_or: assert property (
      (!ts_block && mw.address_modifier_field != 4'h0)
      ##1 1'b1 |-> (cs_addr[4:1] & $past(mw.address_modifier_field))
      == $past(mw.address_modifier_field))
      else $error("modifier not ORed in");
   a_fail_even_addr: assert property (
      (testing && !pass) |=> (!cs_addr[0] && !cond_passed))
      else $error("fail address odd");
   a_normalize_flag_tracks_alu: assert property (
      ##1 flags.normalize_flag ==
      ($past(dp.alu_out[`SIGN_BIT]) ^ $past(dp.alu_out[`NORMALIZE_FLAG_BIT])))
      else $error("normalize flag wrong");
   a_mul_sign_vote: assert property (
      (dp.a_in_sign && dp.b_in_sign) |=> flags.multiply_sign_flag)
      else $error("multiply sign not set");
   a_alu_flags_hold: assert property (
      !sampling |=> $stable({flags.alu_all_ones, flags.alu_sign_flag,
      flags.alu_carry_flag, flags.alu_zero_flag}))
      else $error("alu flags moved");
   a_ovf_ir_directed_test_clear: assert property (
      (testing && pass && mw.condition_select == `GF_IR_DIRECTED_TEST &&
      ir[`IR_DIRECTED_TEST_OVF_BIT]) |=> !flags.overflow_flag)
      else $error("overflow not cleared");
   a_ovf_no_clear: assert property (
      (flags.overflow_flag && mw.sample_field == `SF_NONE &&
      !testing) |=> flags.overflow_flag)
      else $error("sampling cleared overflow");
   a_shift_counter_overflow_minus_one: assert property (
      (mw.test_field == `TF_PASS_FALSE && mw.condition_select ==
      `GF_SHIFT_COUNTER_OVERFLOW && dp.shift_count == `SHIFT_CNT_MINUS1) |=> !cond_passed)
      else $error("counter overflow not seen");

   c_test_fail: cover property (testing && !pass);
   c_io_request: cover property (io_req && mw.high_mask_bit);
   c_ir_directed_test_clear: cover property (
      flags.overflow_flag && testing && mw.condition_select == `GF_IR_DIRECTED_TEST);
   c_byte_store: cover property (byte_store ##1 byte_select_right);
endmodule : useq_next_addr

// ---- useq_store.sv ----
/*
 Control store model, loaded by the bench.
 Assumes a registered cs_addr.
*/
`timescale 1ns/1ps
module useq_store
(
   input wire logic aclk, // Clock
   input wire logic [8:0] cs_addr, // Read address
   input wire logic wr_en, // Load strobe
   input wire logic [8:0] wr_addr, // Load address
   input wire useq_pkg::microword_t wr_word, // Load word
   output useq_pkg::microword_t rd_word // Current microword
);
   useq_pkg::microword_t mem [512];
   // Loads on the clock; unloaded words stay unknown on purpose
   always_ff @(posedge aclk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_word;
      end
   end
   // Asynchronous read, so one address gives one word per cycle
   assign rd_word = mem[cs_addr];
endmodule : useq_store

// ---- test_microsequencer_next_address.sv ----
/*
 Bench for the next-address block and its switch register.
 Assumes registered answers and a 50 MHz aclk.
*/
`timescale 1ns/1ps
`include "useq_defs.svh"
`define CHK(a, e) \
   begin \
      checks_done++; \
      if ((a) !== (e)) \
      begin \
         mismatches++; \
         $display("ERROR %0t: got %h want %h", $time, (a), (e)); \
      end \
   end
module test_microsequencer_next_address;
   logic aclk, aresetn = 1'h0, use_store = 1'h0, wr_en = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, cond_passed, byte_select_right;
   logic awready, wready, bvalid, arready, rvalid;
   useq_pkg::microword_t mw = '0, m = '0, wr_word = '0, mw_in, st_word;
   useq_pkg::datapath_t dp = '0, d = '0;
   useq_pkg::flags_t flags;
   logic [15:0] ir = '0;
   logic [8:0] cs_addr, wr_addr = '0;
   logic [`AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [1:0] bresp, rresp;
   logic [3:0] gfs [8] = '{4'h1, 4'h2, 4'h4, 4'hc, 4'hc, 4'h5, 4'hb, 4'hd};
   logic cv [8] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
   logic [8:0] chain [3] = '{9'h023, 9'h040, 9'h000};
   int mismatches = 0, checks_done = 0, k;
   // Store drives the microword in the chain test
   assign mw_in = use_store ? st_word : mw;
   useq_next_addr dut
   (
      .aclk(aclk), .aresetn(aresetn), .mw(mw_in), .ir(ir), .dp(dp),
      .cs_addr(cs_addr), .cond_passed(cond_passed),
      .byte_select_right(byte_select_right), .flags(flags),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   useq_store store
   (
      .aclk(aclk), .cs_addr(cs_addr), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_word(wr_word), .rd_word(st_word)
   );
   // Free-running 50 MHz clock
   initial
   begin
      aclk = 1'h0;
      forever #10 aclk = ~aclk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude
   // A spent wait ends the run
   task automatic bound(input int n);
      if (n >= 50)
      begin
         mismatches++;
         $display("ERROR %0t: no answer", $time);
         conclude();
      end
   endtask : bound
   // One microinstruction, checked just after its edge
   task automatic run(input logic [15:0] i);
      @(posedge aclk);
      mw <= m;
      ir <= i;
      dp <= d;
      @(posedge aclk);
      #1;
   endtask : run
   task automatic ld(input logic [8:0] a);
      @(posedge aclk);
      wr_en <= 1'h1;
      wr_addr <= a;
      wr_word <= m;
      @(posedge aclk);
      wr_en <= 1'h0;
   endtask : ld
   // Each channel drops at the edge that takes it
   task automatic axw(input logic [3:0] a, input logic [31:0] v,
      input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1 && n < 50);
      bready <= 1'h0;
      bound(n);
      `CHK(bresp, er)
   endtask : axw
   task automatic axr(input logic [3:0] a, input logic [31:0] ev,
      input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready)
            arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1 && n < 50);
      rready <= 1'h0;
      bound(n);
      `CHK(rdata, ev)
      `CHK(rresp, er)
   endtask : axr
   // Expected address; lo is the code 0-3 contribution
   function automatic logic [8:0] ea(input useq_pkg::microword_t w,
      input logic [15:0] i, input logic [4:0] lo);
      logic io;
      logic blk;
      logic [4:0] c;
      io = w.sample_field == 2'h0 && w.memory_op_field[3:1] == 3'h7;
      blk = io || w.test_field != 2'h0 || ^w.register_extract_field
         || w.condition_select[2] && !w.sample_field[0];
      c = lo;
      if (w.field_select_code > 4'h3)
         c = 5'(i >> (w.field_select_code - 4'h4));
      c = c & {w.high_mask_bit & !io, w.low_mask_field};
      return {w.high_address_field, 4'h0} | 9'(c)
         | (blk ? 9'h0 : {4'h0, w.address_modifier_field, 1'h0});
   endfunction : ea
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      // Chain: each word names the next
      m.high_address_field = 5'h02;
      m.low_mask_field = 4'h3;
      ld(9'h000);
      m.high_address_field = 5'h04;
      m.low_mask_field = 4'h0;
      ld(9'h023);
      m = '0;
      ld(9'h040);
      use_store <= 1'h1;
      for (k = 0; k < 3; k++)
      begin
         @(posedge aclk);
         #1;
         `CHK(cs_addr, chain[k])
      end
      use_store <= 1'h0;
      $display("test chain done");
      axr(4'h0, 32'h0, `RESP_OKAY);
      axw(4'h0, 32'hfffffff9, `RESP_OKAY);
      axr(4'h0, 32'h9, `RESP_OKAY);
      axw(4'h8, 32'h1, `RESP_SLVERR);
      axr(4'h8, 32'h0, `RESP_SLVERR);
      $display("test registers done");
      for (k = 4; k < 16; k++)
      begin
         m = '0;
         m.field_select_code = 4'(k);
         m.low_mask_field = 4'hf;
         m.high_mask_bit = 1'h1;
         m.high_address_field = 5'h10;
         run(16'ha5c3);
         `CHK(cs_addr, ea(m, 16'ha5c3, 5'h0))
      end
      axr(4'h4, {7'h0, ea(m, 16'ha5c3, 5'h0), 16'h0}, `RESP_OKAY);
      m = '0;
      m.low_mask_field = 4'h5;
      m.high_mask_bit = 1'h1;
      m.high_address_field = 5'h02;
      m.address_modifier_field = 4'h4;
      run(16'h0);
      `CHK(cs_addr, ea(m, 16'h0, 5'h1f))
      m.high_mask_bit = 1'h0;
      run(16'h0);
      `CHK(cs_addr, ea(m, 16'h0, 5'h1f))
      m.field_select_code = 4'h1;
      m.low_mask_field = 4'hf;
      m.high_mask_bit = 1'h1;
      d.interrupt_flag = 1'h1;
      run(16'h0);
      `CHK(cs_addr, ea(m, 16'h0, 5'h1e))
      m.field_select_code = 4'h3;
      d = '0;
      run(16'h0);
      `CHK(cs_addr, ea(m, 16'h0, 5'h1f))
      // Modifier must stay out
      for (k = 0; k < 5; k++)
      begin
         m = '0;
         m.address_modifier_field = 4'hf;
         m.high_mask_bit = 1'h1;
         m.low_mask_field = 4'hf;
         m.high_address_field = 5'h0a;
         case (k)
            0: m.register_extract_field = 2'h1;
            1: m.register_extract_field = 2'h2;
            2: m.condition_select = 4'h4;
            3: m.memory_op_field = 4'he;
            default: {m.sample_field, m.condition_select} = 6'h24;
         endcase
         run(16'h0);
         `CHK(cs_addr, ea(m, 16'h0, 5'h1f))
      end
      $display("test addressing done");
      for (k = 0; k < 16; k++)
      begin
         m = '0;
         m.low_mask_field = 4'hf;
         m.high_mask_bit = 1'h1;
         m.high_address_field = 5'h06;
         m.address_modifier_field = 4'h5;
         m.test_field = 2'(2 + k[0]);
         m.condition_select = gfs[k[3:1]];
         d = '0;
         d.io_sense_response = 1'h1;
         d.shift_count = (k[3:1] == 3'h3) ? 8'hff : 8'hfe;
         d.gpr_test = 3'h1;
         d.input_register_sign = 1'h1;
         run(16'h0008);
         `CHK(cond_passed, cv[k[3:1]] ^ k[0])
         `CHK(cs_addr, (cv[k[3:1]] ^ k[0]) ? 9'h07f : 9'h06a)
      end
      $display("test conditions done");
      // A test sees normalize one step late
      m = '0;
      m.test_field = 2'h2;
      m.condition_select = 4'he;
      d = '0;
      d.alu_out = 16'h4000;
      run(16'h0);
      `CHK(cond_passed, 1'h0)
      `CHK(flags.normalize_flag, 1'h1)
      run(16'h0);
      `CHK(cond_passed, 1'h1)
      d.alu_out = 16'hc000;
      d.b_in_sign = 1'h1;
      run(16'h0);
      `CHK(flags.normalize_flag, 1'h0)
      `CHK(flags.multiply_sign_flag, 1'h1)
      d.b_in_sign = 1'h0;
      run(16'h0);
      `CHK(flags.multiply_sign_flag, 1'h0)
      m = '0;
      m.direction_bit = 1'h1;
      m.shift_enable_value = 1'h1;
      d.a_reg_sign = 1'h1;
      run(16'h0);
      `CHK(flags.quotient_flag, 1'h1)
      `CHK(flags.shift_flag, 1'h1)
      m.shift_control_field = 1'h1;
      m.literal_field = 2'h2;
      d = '0;
      run(16'h0);
      `CHK(flags.quotient_flag, 1'h1)
      `CHK(flags.shift_flag, 1'h1)
      m = '0;
      m.sample_field = 2'h1;
      m.memory_op_field = 4'h3;
      d.a_shifted = 1'h1;
      d.a_reg_lsb = 1'h1;
      run(16'h0);
      `CHK(byte_select_right, 1'h1)
      d.a_reg_lsb = 1'h0;
      run(16'h0);
      `CHK(byte_select_right, 1'h0)
      `CHK(flags.byte_address_flag, 1'h0)
      m = '0;
      m.field_select_code = 4'h2;
      m.low_mask_field = 4'h3;
      m.high_address_field = 5'h01;
      run(16'h0);
      `CHK(cs_addr, ea(m, 16'h0, 5'h1e))
      // ALU flags move only when sampling is coded
      m = '0;
      m.condition_select = 4'h2;
      d = '0;
      d.alu_out = 16'hffff;
      d.alu_carry = 1'h1;
      run(16'h0);
      `CHK(flags[3:0], 4'he)
      m.condition_select = 4'h0;
      d = '0;
      run(16'h0);
      `CHK(flags[3:0], 4'he)
      m.condition_select = 4'h2;
      run(16'h0);
      `CHK(flags[3:0], 4'h1)
      $display("test flags done");
      m = '0;
      m.sample_field = 2'h1;
      m.condition_select = 4'h2;
      run(16'h0);
      `CHK(flags.overflow_flag, 1'h1)
      m = '0;
      m.condition_select = 4'h8;
      run(16'h0);
      `CHK(flags.overflow_flag, 1'h1)
      m.test_field = 2'h2;
      m.condition_select = 4'h5;
      run(16'h0001);
      `CHK(cond_passed, 1'h1)
      `CHK(flags.overflow_flag, 1'h0)
      m = '0;
      m.sample_field = 2'h1;
      m.condition_select = 4'h2;
      run(16'h0);
      @(posedge aclk);
      aresetn <= 1'h0;
      @(posedge aclk);
      #1;
      `CHK(flags.overflow_flag, 1'h0)
      `CHK(cs_addr, 9'h0)
      $display("test overflow done");
      conclude();
   end
endmodule : test_microsequencer_next_address
